// ===== logic/trp_relay_peak_ctrl.sv
// Decision logic of a panel meter: range warnings, peak detect and hold, relay and LED control.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module trp_relay_peak_ctrl
	import trp_pkg::*;
#(
	parameter logic [31:0] QV_TIMEOUT_CYC = QV_TIMEOUT_CYC_D,
	parameter logic [31:0] QV_ALT_CYC     = QV_ALT_CYC_D,
	parameter logic [31:0] DP_BLINK_CYC   = DP_BLINK_CYC_D
)(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               meas_valid,
	input  wire logic signed [31:0] meas_value,
	input  wire logic               meas_hi_range,
	input  wire logic               meas_lo_range,
	input  wire logic               key_up,
	input  wire logic               key_down,
	input  wire logic               key_esc,
	output logic                    relay_out,
	output logic                    led_out,
	output trp_disp_t               disp_code,
	output logic signed [31:0]      disp_value,
	output logic                    dp_flash
);

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] thr1;
		logic [31:0] thr2;
		logic [31:0] hysteresis_width;
		logic [31:0] ton;
		logic [31:0] off_delay;
		logic [31:0] pamp;
		logic [31:0] ptime;
		logic [31:0] tunit;
		logic [31:0] tdiv;
		logic        tick;
		logic        eval;
		logic [31:0] cur;
		logic        hi;
		logic        lo;
		logic        armed;
		logic [31:0] pmin;
		logic [31:0] pmax;
		logic [31:0] peak;
		logic        pdet;
		logic        pshow;
		logic [31:0] ptimer;
		logic        relay;
		logic [31:0] dcnt;
		logic        qv_act;
		logic        qv_idx;
		logic        qv_name;
		logic [31:0] qv_cnt;
		logic [31:0] alt_cnt;
		logic [31:0] blink_cnt;
		logic        dp;
		trp_disp_t   dcode;
		logic [31:0] dval;
		logic        relay_o;
		logic        led_o;
	} trp_state_t;

	trp_state_t         st_ff;
	trp_state_t         nxt_st;
	logic [1:0]         mode;
	logic [1:0]         alarm;
	logic signed [31:0] src_val;
	logic signed [31:0] lo_thr;
	logic signed [31:0] hi_thr;
	logic               above_lo;
	logic               above_hi;
	logic               zone_a;
	logic               desired;
	logic [31:0]        dly;
	logic               crit;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : wmask

	// True when a - b is at least amp, in signed arithmetic without overflow.
	function automatic logic diff_ge(input logic [31:0] a, input logic [31:0] b, input logic [31:0] amp);
		logic signed [33:0] d;
		d = $signed({{2{a[31]}}, a}) - $signed({{2{b[31]}}, b});
		return d >= $signed({2'b00, amp});
	endfunction : diff_ge

	function automatic logic is_ovf(input logic [31:0] v);
		return ($signed(v) > DISP_MAX) || ($signed(v) < DISP_MIN);
	endfunction : is_ovf

	// ----------------------------------------------------------------
	// Zone evaluation
	// ----------------------------------------------------------------
	assign mode    = st_ff.ctrl[CTRL_MODE_LSB +: 2];
	assign alarm   = st_ff.ctrl[CTRL_AL_LSB +: 2];
	assign crit    = st_ff.hi | st_ff.lo;
	assign src_val = st_ff.ctrl[CTRL_SRC_PEAK] ? st_ff.peak : st_ff.cur;
	assign lo_thr  = (mode == MODE_TWO && $signed(st_ff.thr2) < $signed(st_ff.thr1)) ? st_ff.thr2 : st_ff.thr1;
	assign hi_thr  = ($signed(st_ff.thr2) < $signed(st_ff.thr1)) ? st_ff.thr1 : st_ff.thr2;
	assign zone_a  = (mode == MODE_TWO) ? (above_lo && !above_hi) : above_lo;
	assign desired = st_ff.ctrl[CTRL_SEL_ON] ? zone_a : !zone_a;
	assign dly     = desired ? st_ff.ton : st_ff.off_delay;

	// Both comparators share hysteresis and the sample strobe of each new result.
	trp_zone_hysteresis_width u_zone_lo (
		.clk    (clk),
		.rstn   (rstn),
		.sample (st_ff.eval),
		.value  (src_val),
		.thr    (lo_thr),
		.hysteresis_width   (st_ff.hysteresis_width),
		.above  (above_lo)
	);

	trp_zone_hysteresis_width u_zone_hi (
		.clk    (clk),
		.rstn   (rstn),
		.sample (st_ff.eval),
		.value  (src_val),
		.thr    (hi_thr),
		.hysteresis_width   (st_ff.hysteresis_width),
		.above  (above_hi)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// Write channel: address and data are taken in either order.
		if (st_ff.awready && s_axi_awvalid) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (st_ff.wready && s_axi_wvalid) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = RESP_OKAY;
			unique case (st_ff.awaddr)
				REG_CTRL:      nxt_st.ctrl  = wmask(st_ff.ctrl, st_ff.wdata, st_ff.wstrb) & CTRL_MASK;
				REG_THR1:      nxt_st.thr1  = wmask(st_ff.thr1, st_ff.wdata, st_ff.wstrb);
				REG_THR2:      nxt_st.thr2  = wmask(st_ff.thr2, st_ff.wdata, st_ff.wstrb);
				REG_HYSTERESIS_WIDTH:      nxt_st.hysteresis_width  = wmask(st_ff.hysteresis_width, st_ff.wdata, st_ff.wstrb);
				REG_ON_DLY:    nxt_st.ton   = wmask(st_ff.ton, st_ff.wdata, st_ff.wstrb);
				REG_OFF_DLY:   nxt_st.off_delay  = wmask(st_ff.off_delay, st_ff.wdata, st_ff.wstrb);
				REG_PEAK_AMP:  nxt_st.pamp  = wmask(st_ff.pamp, st_ff.wdata, st_ff.wstrb);
				REG_PEAK_TIME: nxt_st.ptime = wmask(st_ff.ptime, st_ff.wdata, st_ff.wstrb);
				REG_TIME_UNIT: nxt_st.tunit = wmask(st_ff.tunit, st_ff.wdata, st_ff.wstrb);
				REG_STATUS, REG_PEAK_VAL, REG_DISP_VAL: nxt_st.bresp = RESP_OKAY;
				default:       nxt_st.bresp = RESP_SLVERR;
			endcase
		end
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
		// Read channel.
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (st_ff.arready && s_axi_arvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL:      nxt_st.rdata = st_ff.ctrl;
				REG_THR1:      nxt_st.rdata = st_ff.thr1;
				REG_THR2:      nxt_st.rdata = st_ff.thr2;
				REG_HYSTERESIS_WIDTH:      nxt_st.rdata = st_ff.hysteresis_width;
				REG_ON_DLY:    nxt_st.rdata = st_ff.ton;
				REG_OFF_DLY:   nxt_st.rdata = st_ff.off_delay;
				REG_PEAK_AMP:  nxt_st.rdata = st_ff.pamp;
				REG_PEAK_TIME: nxt_st.rdata = st_ff.ptime;
				REG_TIME_UNIT: nxt_st.rdata = st_ff.tunit;
				REG_STATUS:    nxt_st.rdata = {24'h000000, st_ff.qv_idx, st_ff.qv_act, st_ff.pshow,
					st_ff.lo, st_ff.hi, st_ff.dp, st_ff.led_o, st_ff.relay_o};
				REG_PEAK_VAL:  nxt_st.rdata = st_ff.peak;
				REG_DISP_VAL:  nxt_st.rdata = st_ff.dval;
				default: begin
					nxt_st.rdata = 32'h00000000;
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		nxt_st.arready = !nxt_st.rvalid;

		// Time-unit tick; a unit of zero is treated as one cycle.
		nxt_st.tick = 1'b0;
		if (st_ff.tdiv + 32'h1 >= st_ff.tunit) begin
			nxt_st.tdiv = 32'h00000000;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.tdiv = st_ff.tdiv + 32'h1;
		end

		// New result and peak detection.
		nxt_st.eval = meas_valid;
		nxt_st.pdet = 1'b0;
		if (key_esc && st_ff.ctrl[CTRL_HOLD] && st_ff.ptime == 32'h0) begin
			nxt_st.pshow = 1'b0;
		end
		if (st_ff.pshow && st_ff.tick && st_ff.ptime != 32'h0) begin
			if (st_ff.ptimer + 32'h1 >= st_ff.ptime) begin
				nxt_st.pshow = 1'b0;
			end else begin
				nxt_st.ptimer = st_ff.ptimer + 32'h1;
			end
		end
		if (meas_valid) begin
			nxt_st.cur = meas_value;
			nxt_st.hi  = meas_hi_range;
			nxt_st.lo  = meas_lo_range && !meas_hi_range;
			if (!meas_hi_range && !meas_lo_range) begin
				if (!st_ff.armed) begin
					if ($signed(meas_value) < $signed(st_ff.pmin)) begin
						nxt_st.pmin = meas_value;
					end
					if (diff_ge(meas_value, st_ff.pmin, st_ff.pamp)) begin
						nxt_st.armed = 1'b1;
						nxt_st.pmax  = meas_value;
					end
				end else if ($signed(meas_value) > $signed(st_ff.pmax)) begin
					nxt_st.pmax = meas_value;
				end else if (diff_ge(st_ff.pmax, meas_value, st_ff.pamp)) begin
					nxt_st.armed = 1'b0;
					nxt_st.pmin  = meas_value;
					nxt_st.peak  = st_ff.pmax;
					nxt_st.pdet  = 1'b1;
					if (st_ff.ptime != 32'h0 || st_ff.ctrl[CTRL_HOLD]) begin
						nxt_st.pshow  = 1'b1;
						nxt_st.ptimer = 32'h00000000;
					end
				end
			end
		end

		// Relay control with delays and critical override.
		if (mode == MODE_UNUSED) begin
			nxt_st.relay = 1'b0;
			nxt_st.dcnt  = 32'h00000000;
		end else if (crit && alarm != AL_KEEP) begin
			nxt_st.relay = (alarm == AL_ON);
			nxt_st.dcnt  = 32'h00000000;
		end else if (crit || desired == st_ff.relay) begin
			nxt_st.dcnt = 32'h00000000;
		end else if (dly == 32'h0) begin
			nxt_st.relay = desired;
			nxt_st.dcnt  = 32'h00000000;
		end else if (st_ff.tick) begin
			if (st_ff.dcnt + 32'h1 >= dly) begin
				nxt_st.relay = desired;
				nxt_st.dcnt  = 32'h00000000;
			end else begin
				nxt_st.dcnt = st_ff.dcnt + 32'h1;
			end
		end
		nxt_st.relay_o = st_ff.relay && st_ff.ctrl[CTRL_FITTED];
		nxt_st.led_o   = st_ff.relay;

		// Quick view of the thresholds.
		if (st_ff.qv_act) begin
			nxt_st.qv_cnt = st_ff.qv_cnt + 32'h1;
			if (st_ff.alt_cnt + 32'h1 >= QV_ALT_CYC) begin
				nxt_st.alt_cnt = 32'h00000000;
				nxt_st.qv_name = !st_ff.qv_name;
			end else begin
				nxt_st.alt_cnt = st_ff.alt_cnt + 32'h1;
			end
			if (key_esc || st_ff.qv_cnt + 32'h1 >= QV_TIMEOUT_CYC) begin
				nxt_st.qv_act = 1'b0;
			end
		end
		if (key_up || key_down) begin
			nxt_st.qv_act  = 1'b1;
			nxt_st.qv_idx  = st_ff.qv_act && mode == MODE_TWO && !st_ff.qv_idx;
			nxt_st.qv_name = 1'b1;
			nxt_st.qv_cnt  = 32'h00000000;
			nxt_st.alt_cnt = 32'h00000000;
		end

		// Decimal point flash while a peak is shown.
		if (!st_ff.pshow) begin
			nxt_st.blink_cnt = 32'h00000000;
			nxt_st.dp        = 1'b0;
		end else if (st_ff.blink_cnt + 32'h1 >= DP_BLINK_CYC) begin
			nxt_st.blink_cnt = 32'h00000000;
			nxt_st.dp        = !st_ff.dp;
		end else begin
			nxt_st.blink_cnt = st_ff.blink_cnt + 32'h1;
		end

		// Display selection, highest priority first.
		nxt_st.dval = st_ff.cur;
		if (st_ff.qv_act) begin
			nxt_st.dcode = st_ff.qv_name ? DISP_NAME : DISP_THR;
			nxt_st.dval  = st_ff.qv_name ? {31'h00000000, st_ff.qv_idx} : (st_ff.qv_idx ? st_ff.thr2 : st_ff.thr1);
		end else if (st_ff.hi) begin
			nxt_st.dcode = DISP_HI;
		end else if (st_ff.lo) begin
			nxt_st.dcode = DISP_LO;
		end else if (is_ovf(st_ff.cur)) begin
			nxt_st.dcode = DISP_OV;
		end else if (st_ff.pshow) begin
			nxt_st.dcode = is_ovf(st_ff.peak) ? DISP_OV : DISP_PEAK;
			nxt_st.dval  = st_ff.peak;
		end else begin
			nxt_st.dcode = DISP_VALUE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_ff       <= '0;
			st_ff.ctrl  <= CTRL_RST;
			st_ff.tunit <= TUNIT_RST;
			st_ff.pmin  <= ZERO_RST;
			st_ff.dcode <= DISP_VALUE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rresp   = st_ff.rresp;
	assign s_axi_rdata   = st_ff.rdata;
	assign relay_out     = st_ff.relay_o;
	assign led_out       = st_ff.led_o;
	assign disp_code     = st_ff.dcode;
	assign disp_value    = st_ff.dval;
	assign dp_flash      = st_ff.dp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_hi_sample;
		meas_valid && meas_hi_range && !st_ff.qv_act && !key_up && !key_down;
	endsequence

	sequence s_no_key;
		!key_up && !key_down;
	endsequence

	a_hi_warning: assert property (s_hi_sample ##1 s_no_key |=> disp_code == DISP_HI)
		else $error("high range warning not shown");

	a_ovf_warning: assert property (meas_valid && !meas_hi_range && !meas_lo_range && is_ovf(meas_value)
		&& !st_ff.qv_act && !key_up && !key_down ##1 s_no_key |=> disp_code == DISP_OV)
		else $error("overflow warning not shown");

	a_qv_start: assert property (key_up && !st_ff.qv_act ##1 !key_esc |=> disp_code == DISP_NAME)
		else $error("quick view did not show threshold name");

	a_qv_bound: assert property (st_ff.qv_act |-> st_ff.qv_cnt < QV_TIMEOUT_CYC)
		else $error("quick view outlived its timeout");

	a_peak_restart: assert property (st_ff.pdet && st_ff.pshow |-> st_ff.ptimer == 32'h0)
		else $error("display timer not restarted on new peak");

	a_peak_expire: assert property (st_ff.tick && st_ff.pshow && st_ff.ptime != 32'h0
		&& st_ff.ptimer + 32'h1 >= st_ff.ptime && !meas_valid |=> !st_ff.pshow)
		else $error("peak shown past its display time");

	a_real_nohold: assert property (st_ff.pdet && st_ff.ptime == 32'h0 && !st_ff.ctrl[CTRL_HOLD]
		&& !$past(st_ff.pshow) |-> !st_ff.pshow)
		else $error("real style with zero time held a peak");

	a_dp_quiet: assert property (!st_ff.pshow [*2] |=> !dp_flash)
		else $error("decimal point flashing without a peak");

	a_unused_off: assert property (mode == MODE_UNUSED |=> ##1 !relay_out)
		else $error("unused output energised");

	a_zero_delay: assert property (st_ff.ton == 32'h0 && st_ff.off_delay == 32'h0 && !crit
		&& mode != MODE_UNUSED && desired != st_ff.relay |=> st_ff.relay == $past(desired))
		else $error("zero delay relay did not switch at once");

	a_alarm_force: assert property (crit && alarm == AL_ON && mode != MODE_UNUSED |=> st_ff.relay)
		else $error("alarm behaviour did not force relay on");

	a_led_mirror: assert property (##1 1'b1 |-> led_out == $past(st_ff.relay))
		else $error("LED does not mirror relay state");

	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before bready");

endmodule : trp_relay_peak_ctrl
`default_nettype wire

// ===== logic/trp_pkg.sv
// Constants, types and register map of the threshold, relay and peak decision block.
package trp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ           = 250_000_000;
	localparam int          QV_TIMEOUT_S     = 5;
	localparam int          QV_ALT_MS        = 500;
	localparam int          DP_BLINK_MS      = 250;
	localparam logic [31:0] QV_TIMEOUT_CYC_D = 32'(QV_TIMEOUT_S * CLK_HZ);
	localparam logic [31:0] QV_ALT_CYC_D     = 32'(QV_ALT_MS * (CLK_HZ / 1000));
	localparam logic [31:0] DP_BLINK_CYC_D   = 32'(DP_BLINK_MS * (CLK_HZ / 1000));

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_THR1      = 8'h04;
	localparam logic [7:0] REG_THR2      = 8'h08;
	localparam logic [7:0] REG_HYSTERESIS_WIDTH      = 8'h0C;
	localparam logic [7:0] REG_ON_DLY    = 8'h10;
	localparam logic [7:0] REG_OFF_DLY   = 8'h14;
	localparam logic [7:0] REG_PEAK_AMP  = 8'h18;
	localparam logic [7:0] REG_PEAK_TIME = 8'h1C;
	localparam logic [7:0] REG_TIME_UNIT = 8'h20;
	localparam logic [7:0] REG_STATUS    = 8'h24;
	localparam logic [7:0] REG_PEAK_VAL  = 8'h28;
	localparam logic [7:0] REG_DISP_VAL  = 8'h2C;

	// Control register fields.
	localparam int CTRL_SRC_PEAK = 0;
	localparam int CTRL_HOLD     = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_SEL_ON   = 4;
	localparam int CTRL_AL_LSB   = 5;
	localparam int CTRL_FITTED   = 7;

	localparam logic [31:0] CTRL_MASK  = 32'h000000FF;
	localparam logic [31:0] CTRL_RST   = 32'h00000094;
	localparam logic [31:0] TUNIT_RST  = 32'h0003D090;
	localparam logic [31:0] ZERO_RST   = 32'h00000000;

	localparam logic [1:0] MODE_UNUSED = 2'h0;
	localparam logic [1:0] MODE_ONE    = 2'h1;
	localparam logic [1:0] MODE_TWO    = 2'h2;
	localparam logic [1:0] AL_KEEP     = 2'h0;
	localparam logic [1:0] AL_ON       = 2'h1;
	localparam logic [1:0] AL_OFF      = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Display limits: 999999 and -99999.
	localparam logic signed [31:0] DISP_MAX = 32'sh000F423F;
	localparam logic signed [31:0] DISP_MIN = 32'shFFFE7961;

	typedef enum logic [2:0] {
		DISP_VALUE,
		DISP_HI,
		DISP_LO,
		DISP_OV,
		DISP_PEAK,
		DISP_NAME,
		DISP_THR
	} trp_disp_t;

endpackage : trp_pkg

// ===== logic/trp_zone_hysteresis_width.sv
// Hysteretic comparator of one threshold: tells whether the input is above the threshold band.
`timescale 1ns/10ps
`default_nettype none
module trp_zone_hysteresis_width
	import trp_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               sample,
	input  wire logic signed [31:0] value,
	input  wire logic signed [31:0] thr,
	input  wire logic        [31:0] hysteresis_width,
	output logic                    above
);

	typedef struct packed {
		logic above;
	} trp_hysteresis_width_st_t;

	trp_hysteresis_width_st_t      st_ff;
	trp_hysteresis_width_st_t      nxt_st;
	logic signed [33:0] v_ext;
	logic signed [33:0] hi_border;
	logic signed [33:0] lo_border;

	assign v_ext     = {{2{value[31]}}, value};
	assign hi_border = {{2{thr[31]}}, thr} + $signed({2'b00, hysteresis_width});
	assign lo_border = {{2{thr[31]}}, thr} - $signed({2'b00, hysteresis_width});
	assign above     = st_ff.above;

	// ----------------------------------------------------------------
	// Border crossing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (sample) begin
			if (v_ext > hi_border) begin
				nxt_st.above = 1'b1;
			end else if (v_ext < lo_border) begin
				nxt_st.above = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	a_rise_border: assert property (@(posedge clk) disable iff (!rstn)
		sample && (v_ext > hi_border) |=> above)
		else $error("above not set after upper border crossing");

	a_inside_band: assert property (@(posedge clk) disable iff (!rstn)
		sample && (v_ext <= hi_border) && (v_ext >= lo_border) |=> $stable(above))
		else $error("above changed inside the hysteresis band");

endmodule : trp_zone_hysteresis_width
`default_nettype wire

// ===== verification/trp_meas_model.sv
// Model of the measurement converter that delivers scaled results.
`timescale 1ns/10ps
`default_nettype none
module trp_meas_model (
	input  wire logic          clk,
	output logic               meas_valid,
	output logic signed [31:0] meas_value,
	output logic               meas_hi_range,
	output logic               meas_lo_range
);
	initial {meas_valid, meas_hi_range, meas_lo_range, meas_value} = 35'h0;

	// One result per call; the range flags travel with the strobe.
	task automatic send(input logic signed [31:0] v, input logic [1:0] rng);
		meas_value <= v;
		{meas_hi_range, meas_lo_range} <= rng;
		meas_valid <= 1'b1;
		@(posedge clk);
		meas_valid <= 1'b0;
	endtask : send
endmodule : trp_meas_model
`default_nettype wire

// ===== verification/trp_relay_peak_ctrl_test.sv
// Self-checking bench of the threshold, relay and peak decision block.
`timescale 1ns/10ps
`default_nettype none
module trp_relay_peak_ctrl_test import trp_pkg::*;;
	logic               clk, rstn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, mv, mhi, mlo, rly, led, dpf;
	logic        [7:0]  awa, ara;
	logic        [31:0] wd, rdat, d;
	logic        [1:0]  br, rr, r;
	logic signed [31:0] mval, dval;
	trp_disp_t          dcode;
	int                 num_errors, check_count, cyc;
	logic               ku, kd, ke, dp0;

	trp_meas_model u_trp_meas_model (.clk(clk), .meas_valid(mv), .meas_value(mval), .meas_hi_range(mhi),
		.meas_lo_range(mlo));
	trp_relay_peak_ctrl #(.QV_TIMEOUT_CYC(32'hC8), .QV_ALT_CYC(32'h14), .DP_BLINK_CYC(32'h4)) u_trp_relay_peak_ctrl (
		.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .meas_valid(mv),
		.meas_value(mval), .meas_hi_range(mhi), .meas_lo_range(mlo), .key_up(ku), .key_down(kd),
		.key_esc(ke), .relay_out(rly), .led_out(led), .disp_code(dcode), .disp_value(dval), .dp_flash(dpf));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Bus tasks sample handshakes at the rising edge and release each channel right after its own edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		{awa, wd, awv, wv, bry} <= {a, v, 3'h7};
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!bv);
		bry <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		{ara, arv, rry} <= {a, 2'h3};
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		{d, r} = {rdat, rr};
		rry <= 1'b0;
	endtask : rd

	// One key pulse; returns once the display has had time to react.
	task automatic press(input logic [2:0] k);
		@(posedge clk);
		{ku, kd, ke} <= k;
		@(posedge clk);
		{ku, kd, ke} <= 3'h0;
		@(posedge clk);
		@(negedge clk);
	endtask : press

	task automatic meas(input logic signed [31:0] v, input logic [1:0] g, input int n);
		@(posedge clk);
		u_trp_meas_model.send(v, g);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : meas

	task automatic mr(input logic signed [31:0] v, input logic e);
		meas(v, 2'h0, 5);
		chk("relay", {31'h0, e}, {31'h0, rly});
	endtask : mr

	task automatic mc(input logic signed [31:0] v, input logic [1:0] g, input trp_disp_t e);
		meas(v, g, 5);
		chk("disp_code", 32'(e), 32'(dcode));
	endtask : mc

	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			wrap_up();
		end
	end

	initial begin
		{awv, wv, bry, arv, rry, rstn, awa, ara, wd, ku, kd, ke} = 57'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(REG_CTRL);
		chk("ctrl", CTRL_RST, d);
		rd(REG_TIME_UNIT);
		chk("tunit", TUNIT_RST, d);
		rd(8'h40);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(REG_TIME_UNIT, 32'h1);
		wr(REG_THR1, 32'h64);
		wr(REG_HYSTERESIS_WIDTH, 32'hA);
		mr(32'sh69, 1'b0);
		mr(32'sh6F, 1'b1);
		mr(32'sh5F, 1'b1);
		mr(32'sh59, 1'b0);
		mc(32'sh0, 2'h2, DISP_HI);
		mc(32'sh0, 2'h1, DISP_LO);
		mc(32'sh000F4240, 2'h0, DISP_OV);
		mc(32'shFFFE7960, 2'h0, DISP_OV);
		mc(DISP_MIN, 2'h0, DISP_VALUE);
		wr(REG_ON_DLY, 32'h5);
		wr(REG_OFF_DLY, 32'h32);
		meas(32'shC8, 2'h0, 5);
		chk("relay early", 32'h0, {31'h0, rly});
		mr(32'shC8, 1'b1);
		meas(32'sh0, 2'h0, 1);
		mr(32'shC8, 1'b1);
		meas(32'sh0, 2'h0, 60);
		chk("relay off", 32'h0, {31'h0, rly});
		wr(REG_ON_DLY, 32'h0);
		wr(REG_OFF_DLY, 32'h0);
		wr(REG_THR1, 32'h12C);
		wr(REG_THR2, 32'h64);
		wr(REG_HYSTERESIS_WIDTH, 32'h0);
		wr(REG_CTRL, 32'h98);
		mr(32'shC8, 1'b1);
		mr(32'sh190, 1'b0);
		mr(32'sh32, 1'b0);
		wr(REG_CTRL, 32'h14);
		mr(32'sh190, 1'b0);
		chk("led", 32'h1, {31'h0, led});
		wr(REG_CTRL, 32'h98);
		press(3'h4);
		chk("qv name", 32'(DISP_NAME), 32'(dcode));
		chk("qv index", 32'h0, dval);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("qv thr", 32'(DISP_THR), 32'(dcode));
		chk("qv value", 32'h12C, dval);
		press(3'h2);
		chk("qv next", 32'h1, dval);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("qv value2", 32'h64, dval);
		press(3'h1);
		chk("qv esc", 32'(DISP_VALUE), 32'(dcode));
		press(3'h4);
		repeat (200) @(posedge clk);
		@(negedge clk);
		chk("qv timeout", 32'(DISP_VALUE), 32'(dcode));
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(REG_CTRL);
		chk("ctrl rst", CTRL_RST, d);
		chk("led rst", 32'h0, {31'h0, led});
		wr(REG_TIME_UNIT, 32'hA);
		wr(REG_PEAK_AMP, 32'h32);
		wr(REG_PEAK_TIME, 32'h3);
		wr(REG_CTRL, 32'h95);
		mr(32'sh64, 1'b0);
		meas(32'shC8, 2'h0, 1);
		mc(32'sh32, 2'h0, DISP_PEAK);
		chk("peak", 32'hC8, dval);
		chk("relay peak", 32'h1, {31'h0, rly});
		dp0 = dpf;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("dp_flash", {31'h0, !dp0}, {31'h0, dpf});
		meas(32'sh96, 2'h0, 1);
		mc(32'sh3C, 2'h0, DISP_PEAK);
		repeat (14) @(posedge clk);
		@(negedge clk);
		chk("peak restart", 32'(DISP_PEAK), 32'(dcode));
		chk("new peak", 32'h96, dval);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("peak expiry", 32'(DISP_VALUE), 32'(dcode));
		chk("value back", 32'h3C, dval);
		chk("dp idle", 32'h0, {31'h0, dpf});
		wr(REG_PEAK_TIME, 32'h0);
		wr(REG_CTRL, 32'h96);
		meas(32'shC8, 2'h0, 1);
		mc(32'sh64, 2'h0, DISP_PEAK);
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk("hold", 32'(DISP_PEAK), 32'(dcode));
		press(3'h1);
		chk("hold esc", 32'(DISP_VALUE), 32'(dcode));
		wr(REG_CTRL, 32'h94);
		meas(32'shC8, 2'h0, 1);
		mc(32'sh64, 2'h0, DISP_VALUE);
		rd(REG_PEAK_VAL);
		chk("peak val", 32'hC8, d);
		wr(REG_CTRL, 32'hB4);
		mr(32'shFFFFFF9C, 1'b0);
		meas(32'sh0, 2'h2, 5);
		chk("alarm on", 32'h1, {31'h0, rly});
		wr(REG_CTRL, 32'hD4);
		mr(32'sh64, 1'b1);
		meas(32'sh64, 2'h1, 5);
		chk("alarm off", 32'h0, {31'h0, rly});
		wr(REG_CTRL, 32'h84);
		mr(32'shFFFFFF9C, 1'b1);
		mr(32'sh64, 1'b0);
		mr(32'shFFFFFF9C, 1'b1);
		wr(REG_CTRL, 32'h80);
		mr(32'shFFFFFF9C, 1'b0);
		wrap_up();
	end
endmodule : trp_relay_peak_ctrl_test
`default_nettype wire
